// File: an_partner_base_page_upper.sv
`timescale 1ns/100ps
module an_partner_base_page_upper (
  input wire logic aclk, // clock, 250 MHz
  input wire logic aresetn, // sync reset, active low
  input wire logic [an_partner_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [an_partner_pkg::DATA_W-1:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [an_partner_pkg::ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [an_partner_pkg::DATA_W-1:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [an_partner_pkg::PAGE_W-1:0] rx_base_page, // live received base page
  output logic tx_high_swing // resolved transmit level, 1 = high
);

  function automatic an_partner_pkg::sel_e decode(input logic [an_partner_pkg::ADDR_W-1:0] a);
    if (a == an_partner_pkg::ADDR_LOCAL) begin
      return an_partner_pkg::SEL_LOCAL;
    end else if (a == an_partner_pkg::ADDR_LOW) begin
      return an_partner_pkg::SEL_LOW;
    end else if (a == an_partner_pkg::ADDR_MID) begin
      return an_partner_pkg::SEL_MID;
    end else if (a == an_partner_pkg::ADDR_HIGH) begin
      return an_partner_pkg::SEL_HIGH;
    end else if (a == an_partner_pkg::ADDR_STATUS) begin
      return an_partner_pkg::SEL_STATUS;
    end else begin
      return an_partner_pkg::SEL_NONE;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // snapshot of the upper partner words

  logic ar_take;
  an_partner_pkg::sel_e ar_sel;
  logic capture;
  logic [2*an_partner_pkg::WORD_W-1:0] snap_d;
  logic [2*an_partner_pkg::WORD_W-1:0] snap_q;

  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign ar_sel = decode(s_axi_araddr);
  assign capture = ar_take && (ar_sel == an_partner_pkg::SEL_LOW);
  // reserved positions masked at capture so they can never read back
  assign snap_d = rx_base_page[an_partner_pkg::PAGE_W-1:an_partner_pkg::WORD_W]
                  & an_partner_pkg::SNAP_MASK;

  page_snapshot #(
    .WIDTH(2*an_partner_pkg::WORD_W)
  ) u_snap (
    .aclk(aclk),
    .aresetn(aresetn),
    .capture(capture),
    .d(snap_d),
    .q(snap_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // write channel

  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic aw_held_reg, aw_held_next;
  logic w_held_reg, w_held_next;
  logic [an_partner_pkg::ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic [an_partner_pkg::WORD_W-1:0] w_data_reg, w_data_next;
  logic w_strb1_reg, w_strb1_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic [an_partner_pkg::WORD_W-1:0] local_reg, local_next;
  an_partner_pkg::sel_e aw_sel;

  assign aw_sel = decode(aw_addr_reg);

  always_comb begin
    awready_next = awready_reg;
    wready_next = wready_reg;
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    aw_addr_next = aw_addr_reg;
    w_data_next = w_data_reg;
    w_strb1_next = w_strb1_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    local_next = local_reg;
    if (s_axi_awvalid && awready_reg) begin
      aw_held_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
      awready_next = 1'b0;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_held_next = 1'b1;
      w_data_next = s_axi_wdata[an_partner_pkg::WORD_W-1:0];
      w_strb1_next = s_axi_wstrb[1];
      wready_next = 1'b0;
    end
    if (aw_held_reg && w_held_reg && !bvalid_reg) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = an_partner_pkg::RESP_OKAY;
      // snapshot words have no write path at all
      if (aw_sel == an_partner_pkg::SEL_LOCAL) begin
        if (w_strb1_reg) begin
          local_next = (local_reg & ~an_partner_pkg::LOCAL_MASK)
                       | (w_data_reg & an_partner_pkg::LOCAL_MASK);
        end
      end else if (aw_sel == an_partner_pkg::SEL_NONE) begin
        bresp_next = an_partner_pkg::RESP_DECERR;
      end
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
      awready_next = 1'b1;
      wready_next = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb1_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= an_partner_pkg::RESP_OKAY;
      local_reg <= an_partner_pkg::LOCAL_RESET;
    end else begin
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      aw_addr_reg <= aw_addr_next;
      w_data_reg <= w_data_next;
      w_strb1_reg <= w_strb1_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      local_reg <= local_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit level resolution

  logic swing_reg, swing_next;
  logic local_able, local_req, peer_able, peer_req;

  assign local_able = local_reg[an_partner_pkg::HIGH_SWING_ABLE_BIT];
  assign local_req = local_reg[an_partner_pkg::HIGH_SWING_REQ_BIT];
  // live partner bits: the link resolves before software ever reads
  assign peer_able = rx_base_page[an_partner_pkg::WORD_W*2+an_partner_pkg::HIGH_SWING_ABLE_BIT];
  assign peer_req = rx_base_page[an_partner_pkg::WORD_W*2+an_partner_pkg::HIGH_SWING_REQ_BIT];

  always_comb begin
    swing_next = local_able && peer_able && (local_req || peer_req);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      swing_reg <= 1'b0;
    end else begin
      swing_reg <= swing_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel

  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [an_partner_pkg::DATA_W-1:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [an_partner_pkg::WORD_W-1:0] live_low;

  // forced-role flag comes along in the low word
  assign live_low = rx_base_page[an_partner_pkg::WORD_W-1:0] & an_partner_pkg::LOW_MASK;

  always_comb begin
    arready_next = arready_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (ar_take) begin
      arready_next = 1'b0;
      rvalid_next = 1'b1;
      rresp_next = an_partner_pkg::RESP_OKAY;
      rdata_next = '0;
      case (ar_sel)
        an_partner_pkg::SEL_LOCAL: begin
          rdata_next[an_partner_pkg::WORD_W-1:0] = local_reg;
        end
        an_partner_pkg::SEL_LOW: begin
          rdata_next[an_partner_pkg::WORD_W-1:0] = live_low;
        end
        an_partner_pkg::SEL_MID: begin
          rdata_next[an_partner_pkg::WORD_W-1:0] = snap_q[an_partner_pkg::WORD_W-1:0];
        end
        an_partner_pkg::SEL_HIGH: begin
          rdata_next[an_partner_pkg::WORD_W-1:0] =
            snap_q[2*an_partner_pkg::WORD_W-1:an_partner_pkg::WORD_W];
        end
        an_partner_pkg::SEL_STATUS: begin
          rdata_next[an_partner_pkg::STATUS_SWING_BIT] = swing_reg;
        end
        default: begin
          rresp_next = an_partner_pkg::RESP_DECERR;
        end
      endcase
    end
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
      arready_next = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= an_partner_pkg::RESP_OKAY;
    end else begin
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign tx_high_swing = swing_reg;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  AST_RESET_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> (snap_q == '0))
    else $error("snapshot not zero after reset");

  AST_CAPTURE: assert property (@(posedge aclk) disable iff (!aresetn)
    capture |=> (snap_q == $past(snap_d)))
    else $error("snapshot missed low-word read");

  AST_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    !capture |=> $stable(snap_q))
    else $error("snapshot changed without low-word read");

  AST_MID_READ: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_take && ar_sel == an_partner_pkg::SEL_MID) |=>
      (s_axi_rvalid && s_axi_rdata == {16'h0000, $past(snap_q[15:0])}))
    else $error("mid read not from snapshot");

  AST_HIGH_READ: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_take && ar_sel == an_partner_pkg::SEL_HIGH) |=>
      (s_axi_rvalid && s_axi_rdata == {16'h0000, $past(snap_q[31:16])}))
    else $error("high read not from snapshot");

  AST_FIELDS: assert property (@(posedge aclk) disable iff (!aresetn)
    capture |=> (snap_q[14] == $past(rx_base_page[30]) && snap_q[4] == $past(rx_base_page[20])
      && snap_q[30] == $past(rx_base_page[46]) && snap_q[29] == $past(rx_base_page[45])))
    else $error("partner field position wrong");

  AST_RSVD: assert property (@(posedge aclk) disable iff (!aresetn)
    (snap_q & ~an_partner_pkg::SNAP_MASK) == '0)
    else $error("reserved bit set in snapshot");

  AST_LOW_STROBE: assert property (@(posedge aclk) disable iff (!aresetn)
    capture |=> (s_axi_rvalid && s_axi_rdata[12] == $past(rx_base_page[12])))
    else $error("low read did not answer with forced flag");

  AST_SWING: assert property (@(posedge aclk) disable iff (!aresetn)
    (!local_able || !peer_able) |=> !tx_high_swing)
    else $error("high swing without both able");

  AST_BRESP_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("write response dropped");

  COV_CAPTURE: cover property (@(posedge aclk) disable iff (!aresetn) capture);
  COV_MID_AFTER_LOW: cover property (@(posedge aclk) disable iff (!aresetn)
    capture ##[1:20] (ar_take && ar_sel == an_partner_pkg::SEL_MID));
  COV_WRITE_LOCAL: cover property (@(posedge aclk) disable iff (!aresetn)
    (aw_held_reg && w_held_reg && aw_sel == an_partner_pkg::SEL_LOCAL));
  COV_SWING: cover property (@(posedge aclk) disable iff (!aresetn) $rose(tx_high_swing));

endmodule

// File: an_partner_pkg.sv
package an_partner_pkg;

  localparam int ADDR_W = 14;
  localparam int DATA_W = 32;
  localparam int WORD_W = 16;
  localparam int PAGE_W = 48;

  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_LOCAL = 12'h204;
  localparam logic [11:0] IDX_LOW = 12'h205;
  localparam logic [11:0] IDX_MID = 12'h206;
  localparam logic [11:0] IDX_HIGH = 12'h207;
  localparam logic [11:0] IDX_STATUS = 12'h210;

  localparam logic [ADDR_W-1:0] ADDR_LOCAL = {IDX_LOCAL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_LOW = {IDX_LOW, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_MID = {IDX_MID, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_HIGH = {IDX_HIGH, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'b00};

  // field positions inside the 16-bit words
  localparam int LOW_ROLE_FORCED_BIT = 12;
  localparam int MID_LONG_REACH_BIT = 14;
  localparam int MID_GIGABIT_BIT = 7;
  localparam int MID_SHORT_FD_BIT = 6;
  localparam int MID_FAST_BIT = 5;
  localparam int MID_LEADER_BIT = 4;
  localparam int HIGH_ENERGY_BIT = 14;
  localparam int HIGH_SWING_ABLE_BIT = 13;
  localparam int HIGH_SWING_REQ_BIT = 12;
  localparam int HIGH_SHORT_HD_BIT = 11;
  localparam int STATUS_SWING_BIT = 0;

  // implemented bits; everything else reads zero
  localparam logic [WORD_W-1:0] LOW_MASK = 16'hfc1f;
  localparam logic [WORD_W-1:0] MID_MASK = 16'h40f0;
  localparam logic [WORD_W-1:0] HIGH_MASK = 16'h7800;
  localparam logic [WORD_W-1:0] LOCAL_MASK = 16'h3000;
  localparam logic [2*WORD_W-1:0] SNAP_MASK = {HIGH_MASK, MID_MASK};

  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
  localparam logic [WORD_W-1:0] LOCAL_RESET = 16'h0000;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  typedef enum logic [5:0] {
    SEL_NONE = 6'b000001,
    SEL_LOCAL = 6'b000010,
    SEL_LOW = 6'b000100,
    SEL_MID = 6'b001000,
    SEL_HIGH = 6'b010000,
    SEL_STATUS = 6'b100000
  } sel_e;

endpackage

// File: page_snapshot.sv
`timescale 1ns/100ps
module page_snapshot #(
  parameter int WIDTH = 32
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, active low
  input wire logic capture, // one-cycle load strobe
  input wire logic [WIDTH-1:0] d, // live value
  output logic [WIDTH-1:0] q // held value
);

  // refused at elaboration, before any logic is built
  if (WIDTH < 1) begin : g_bad_width
    $error("page_snapshot: WIDTH must be positive");
  end

  logic [WIDTH-1:0] q_next;

  always_comb begin
    q_next = q;
    if (capture) begin
      q_next = d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= q_next;
    end
  end

endmodule

// File: an_partner_base_page_upper_tb.sv
`timescale 1ns/100ps
module an_partner_base_page_upper_tb;
  logic aclk;
  logic aresetn;
  logic [an_partner_pkg::ADDR_W-1:0] s_axi_awaddr;
  logic s_axi_awvalid;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_wvalid;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready;
  logic [an_partner_pkg::ADDR_W-1:0] s_axi_araddr;
  logic s_axi_arvalid;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready;
  logic [47:0] rx_base_page;
  logic tx_high_swing;
  int n_errors = 0;
  int n_checks = 0;

  an_partner_base_page_upper uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .rx_base_page(rx_base_page), .tx_high_swing(tx_high_swing));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic timed_out(input string what);
    $display("[ERR] %s expected handshake seen none", what);
    n_errors++;
    final_report();
  endtask

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask

  task automatic check_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %b seen %b", what, exp, got);
      n_errors++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic axi_write(input logic [13:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    logic b_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    b_done = 1'b0;
    r = 2'bxx;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 50 && !b_done; i++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        w_done = 1'b1;
      end
      if (aw_done && w_done && s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        b_done = 1'b1;
      end
    end
    if (!b_done) timed_out("write");
  endtask

  task automatic axi_read(input logic [13:0] a, output logic [31:0] d, output logic [1:0] r);
    logic r_done;
    r_done = 1'b0;
    d = 'x;
    r = 2'bxx;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 50 && !r_done; i++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        r_done = 1'b1;
      end
    end
    if (!r_done) timed_out("read");
  endtask

  task automatic read_check(input logic [13:0] a, input string what, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check_resp({what, " resp"}, an_partner_pkg::RESP_OKAY, r);
    check_word(what, exp, d);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // live page is all ones from time zero, so only a capture could make these nonzero
  task automatic t_reset();
    read_check(an_partner_pkg::ADDR_MID, "mid reset", 32'h0000_0000);
    read_check(an_partner_pkg::ADDR_HIGH, "high reset", 32'h0000_0000);
  endtask

  task automatic t_snapshot();
    read_check(an_partner_pkg::ADDR_LOW, "low live", 32'h0000_fc1f);
    read_check(an_partner_pkg::ADDR_MID, "mid capture", 32'h0000_40f0);
    read_check(an_partner_pkg::ADDR_HIGH, "high capture", 32'h0000_7800);
    @(posedge aclk);
    rx_base_page <= 48'h0;
    read_check(an_partner_pkg::ADDR_MID, "mid held", 32'h0000_40f0);
    read_check(an_partner_pkg::ADDR_HIGH, "high held", 32'h0000_7800);
    read_check(an_partner_pkg::ADDR_LOW, "low zero", 32'h0000_0000);
    read_check(an_partner_pkg::ADDR_MID, "mid recapture", 32'h0000_0000);
  endtask

  // one partner bit at a time, so a field moved to a neighbour position shows up
  task automatic t_fields();
    int pos[9] = '{30, 23, 22, 21, 20, 46, 45, 44, 43};
    for (int k = 0; k < 9; k++) begin
      @(posedge aclk);
      rx_base_page <= 48'h1 << pos[k];
      read_check(an_partner_pkg::ADDR_LOW, "low", 32'h0000_0000);
      read_check(pos[k] < 32 ? an_partner_pkg::ADDR_MID : an_partner_pkg::ADDR_HIGH, "field set",
        32'h1 << (pos[k] % 16));
      read_check(pos[k] < 32 ? an_partner_pkg::ADDR_HIGH : an_partner_pkg::ADDR_MID, "other word",
        32'h0000_0000);
    end
  endtask

  task automatic t_forced();
    for (int v = 0; v < 2; v++) begin
      @(posedge aclk);
      rx_base_page <= 48'(v) << 12;
      read_check(an_partner_pkg::ADDR_LOW, "forced flag", 32'(v) << 12);
    end
  endtask

  task automatic t_writes();
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    rx_base_page <= 48'hffff_ffff_ffff;
    read_check(an_partner_pkg::ADDR_LOW, "low ones", 32'h0000_fc1f);
    axi_write(an_partner_pkg::ADDR_MID, 32'h0000_0000, 4'hf, r);
    check_resp("mid write resp", an_partner_pkg::RESP_OKAY, r);
    axi_write(an_partner_pkg::ADDR_HIGH, 32'h0000_0000, 4'hf, r);
    check_resp("high write resp", an_partner_pkg::RESP_OKAY, r);
    read_check(an_partner_pkg::ADDR_MID, "mid after write", 32'h0000_40f0);
    read_check(an_partner_pkg::ADDR_HIGH, "high after write", 32'h0000_7800);
    axi_write(14'h0000, 32'hffff_ffff, 4'hf, r);
    check_resp("unmapped write resp", an_partner_pkg::RESP_DECERR, r);
    axi_read(14'h0004, d, r);
    check_resp("unmapped read resp", an_partner_pkg::RESP_DECERR, r);
  endtask

  // every combination of local and partner able/request
  task automatic t_swing();
    logic [3:0] c;
    logic exp;
    logic [1:0] r;
    for (int i = 0; i < 16; i++) begin
      c = 4'(i);
      exp = c[3] & c[1] & (c[2] | c[0]);
      axi_write(an_partner_pkg::ADDR_LOCAL, {18'h0, c[3], c[2], 12'h0}, 4'hf, r);
      @(posedge aclk);
      rx_base_page <= {2'b00, c[1], c[0], 44'h0};
      repeat (3) @(posedge aclk);
      check_word("tx_high_swing", {31'h0, exp}, {31'h0, tx_high_swing});
      read_check(an_partner_pkg::ADDR_STATUS, "status swing", {31'h0, exp});
    end
    // byte lane 1 off: local bits must not change, swing stays high
    axi_write(an_partner_pkg::ADDR_LOCAL, 32'h0000_0000, 4'h1, r);
    repeat (3) @(posedge aclk);
    check_word("swing kept", 32'h0000_0001, {31'h0, tx_high_swing});
    read_check(an_partner_pkg::ADDR_LOCAL, "local kept", 32'h0000_3000);
  endtask

  // reset in mid-run must drop a captured snapshot and the resolved level
  task automatic t_mid_reset();
    read_check(an_partner_pkg::ADDR_LOW, "low before reset", 32'h0000_0000);
    read_check(an_partner_pkg::ADDR_HIGH, "high before reset", 32'h0000_3000);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    check_word("swing after reset", 32'h0000_0000, {31'h0, tx_high_swing});
    read_check(an_partner_pkg::ADDR_MID, "mid reset again", 32'h0000_0000);
    read_check(an_partner_pkg::ADDR_HIGH, "high reset again", 32'h0000_0000);
    read_check(an_partner_pkg::ADDR_LOCAL, "local reset", 32'h0000_0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = '0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = '0;
    s_axi_wstrb = '0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = '0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    rx_base_page = 48'hffff_ffff_ffff;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_snapshot();
    t_fields();
    t_forced();
    t_writes();
    t_swing();
    t_mid_reset();
    final_report();
  end
endmodule
